//--- core/osc_source_ctrl.sv
// Contract
// - fast rc divided by eight-code divider field
// - secondary ready only when running and stable
// - divisor ready flag gates divisor writes
// - peripheral clock is core clock over 1/2/4/8
// - pll multiplier codes select fifteen to twenty-one or twenty-four
// - current source field reports active clock
// - next source loads from strap at reset
// - lock bit freezes selections when lockable
// - usb pll lock flag reported
// - system pll lock flag, zero when disabled
// - wait enters sleep or idle per bit
// - clock fail flag set by monitor
// - usb clock from fast rc when set
// - secondary oscillator enable bit
// - switch request bit clears when done
// - unimplemented control bits read zero
// - six-bit trim, upper bits read zero
// - divider switch bit clears on completion
// - enabled generator holds values until switch
// - four-bit reference source select
`timescale 1ns/1ps
`include "osc_map.svh"
module osc_source_ctrl
	import osc_pkg::*;
(
	// clock and reset
	input  wire logic            clk_sys_i,
	input  wire logic            srst_i,
	// avalon-mm slave, word addressed
	input  wire logic [1:0]      avs_address_i,
	input  wire logic            avs_read_i,
	input  wire logic            avs_write_i,
	input  wire logic [31:0]     avs_writedata_i,
	input  wire logic [3:0]      avs_byteenable_i,
	output logic      [31:0]     avs_readdata_o,
	output logic                 avs_waitrequest_o,
	// oscillator status pins and configuration straps
	input  wire osc_pin_type     osc_pins_i,
	input  wire osc_strap_type   straps_i,
	// core power events
	input  wire logic            wait_exec_i,
	input  wire logic            wake_event_i,
	// oscillator and reference clock settings
	output osc_clk_cfg_type      clk_cfg_o,
	output osc_ref_cfg_type      ref_cfg_o,
	output logic [5:0]           fast_rc_trim_o,
	output logic                 periph_clk_tick_o,
	// power mode
	output logic                 sleep_mode_o,
	output logic                 idle_mode_o
);

	// derived cycle counts, rounded up as these are least times
	localparam int SW_CYC  = (`OSC_SWITCH_SETTLE_NS + `OSC_CLK_PERIOD_NS - 1) / `OSC_CLK_PERIOD_NS;
	localparam int REF_CYC = (`OSC_REF_SWITCH_NS + `OSC_CLK_PERIOD_NS - 1) / `OSC_CLK_PERIOD_NS;
	localparam logic [7:0] SW_LAST  = 8'(SW_CYC - 1);
	localparam logic [7:0] REF_LAST = 8'(REF_CYC - 1);
	localparam logic [71:0] RATIO_TAB  = `OSC_FAST_RC_RATIO_TAB;
	localparam logic [39:0] FACTOR_TAB = `OSC_PLL_FACTOR_TAB;

	// all state of this block
	typedef struct packed {
		logic               strap_pend;     // straps still to be taken
		logic [1:0]         sw_mon_cfg;     // captured switch-monitor config
		logic [2:0]         fast_rc_div;
		logic [1:0]         pb_div;
		logic [2:0]         pll_mult;
		logic [2:0]         nxt_src;
		logic               sel_lock;
		logic               usb_pll_locked;
		logic               sys_pll_locked;
		logic               sleep_on_wait;
		logic               clock_fail_flag;
		logic               switch_req;
		logic               sec_ready;
		logic [5:0]         trim;
		logic [14:0]        ref_div_stage;  // value software wrote
		logic [3:0]         ref_sel_stage;
		logic               ref_on;
		logic               ref_stop_idle;
		logic               ref_run_sleep;
		logic               ref_div_switch;
		logic               ref_active;
		logic [7:0]         ref_cnt;
		osc_sw_state_type   sw_state;
		logic [7:0]         sw_cnt;
		logic               sleep_mode;
		logic               idle_mode;
		logic               waitreq;
		logic [31:0]        rdata;
		osc_clk_cfg_type    clk;
		osc_ref_cfg_type    refc;
	} osc_state_type;

	osc_state_type  state_r;    // registered state
	osc_state_type  state_nxt;  // next state
	osc_pin_type    pins_s;     // synchronised pins
	osc_strap_type  straps_s;   // synchronised straps
	logic           pb_ready;   // divisor may be written
	logic           pb_tick;    // peripheral clock enable

	// merge write data into an old image under byte enables
	function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return (old & ~m) | (wd & m);
	endfunction

	// pins and straps cross in from outside the clock domain
	osc_sync2 #(
		.W($bits(osc_pin_type) + $bits(osc_strap_type))
	) u_sync (
		.clk_sys_i (clk_sys_i),
		.d_i       ({osc_pins_i, straps_i}),
		.q_o       ({pins_s, straps_s})
	);

	// peripheral bus clock enable and divisor ready
	osc_pb_div u_pb_div (
		.clk_sys_i  (clk_sys_i),
		.srst_i     (srst_i),
		.div_code_i (state_r.pb_div),
		.tick_o     (pb_tick),
		.ready_o    (pb_ready)
	);

	// the whole block: bus slave, switch sequencer, reference staging
	always_comb begin
		logic [31:0] ctrl_img; // control register as read
		logic [31:0] trim_img; // tuning register as read
		logic [31:0] ref_img;  // reference register as read
		logic [31:0] wimg;     // merged write image
		logic        req;      // master has a request up
		logic        wr;       // write takes effect this edge
		logic        locked;   // selections frozen
		logic        tgt_rdy;  // target oscillator usable
		ctrl_img = '0;
		trim_img = '0;
		ref_img  = '0;
		wimg     = '0;
		req      = 1'b0;
		wr       = 1'b0;
		locked   = 1'b0;
		tgt_rdy  = 1'b0;
		state_nxt = state_r;

		// read images; unlisted bits stay zero
		ctrl_img[`OSC_C_FAST_RC_DIV] = state_r.fast_rc_div;
		ctrl_img[`OSC_C_SEC_READY]   = state_r.sec_ready;
		ctrl_img[`OSC_C_PB_READY]    = pb_ready;
		ctrl_img[`OSC_C_PB_DIV]      = state_r.pb_div;
		ctrl_img[`OSC_C_PLL_MULT]    = state_r.pll_mult;
		ctrl_img[`OSC_C_CUR_SRC]     = state_r.clk.core_clock_src;
		ctrl_img[`OSC_C_NXT_SRC]     = state_r.nxt_src;
		ctrl_img[`OSC_C_SEL_LOCK]    = state_r.sel_lock;
		ctrl_img[`OSC_C_USB_LOCK]    = state_r.usb_pll_locked;
		ctrl_img[`OSC_C_SYS_LOCK]    = state_r.sys_pll_locked;
		ctrl_img[`OSC_C_SLEEP_WAIT]  = state_r.sleep_on_wait;
		ctrl_img[`OSC_C_CLK_FAIL]    = state_r.clock_fail_flag;
		ctrl_img[`OSC_C_USB_FAST_RC] = state_r.clk.usb_fast_rc_select;
		ctrl_img[`OSC_C_SEC_ENABLE]  = state_r.clk.sec_osc_enable;
		ctrl_img[`OSC_C_SWITCH_REQ]  = state_r.switch_req;
		trim_img[`OSC_T_TRIM]        = state_r.trim;
		ref_img[`OSC_R_DIV]          = state_r.ref_div_stage;
		ref_img[`OSC_R_ON]           = state_r.ref_on;
		ref_img[`OSC_R_STOP_IDLE]    = state_r.ref_stop_idle;
		ref_img[`OSC_R_OUT_EN]       = state_r.refc.out_enable;
		ref_img[`OSC_R_RUN_SLEEP]    = state_r.ref_run_sleep;
		ref_img[`OSC_R_DIV_SWITCH]   = state_r.ref_div_switch;
		ref_img[`OSC_R_ACTIVE]       = state_r.ref_active;
		ref_img[`OSC_R_SEL]          = state_r.ref_sel_stage;

		// handshake: waitrequest drops for one cycle, one cycle after the request
		req = avs_read_i | avs_write_i;
		wr  = avs_write_i & ~state_r.waitreq;
		state_nxt.waitreq = ~(req & state_r.waitreq);
		if (avs_read_i && state_r.waitreq) begin
			case (avs_address_i)
				`OSC_REG_CTRL: state_nxt.rdata = ctrl_img;
				`OSC_REG_TRIM: state_nxt.rdata = trim_img;
				`OSC_REG_REF:  state_nxt.rdata = ref_img;
				default:       state_nxt.rdata = '0; // unmapped word reads zero
			endcase
		end

		// status sampled from the synchronised pins
		state_nxt.sec_ready      = pins_s.sec_osc_stable & state_r.clk.sec_osc_enable;
		state_nxt.sys_pll_locked = pins_s.sys_pll_lock & state_r.clk.pll_enable;
		state_nxt.usb_pll_locked = pins_s.usb_pll_lock;

		// lock only counts when the straps make it lockable
		locked = state_r.sw_mon_cfg[`OSC_CFG_LOCKABLE] & state_r.sel_lock;

		// control register write
		if (wr && avs_address_i == `OSC_REG_CTRL) begin
			wimg = byte_merge(ctrl_img, avs_writedata_i, avs_byteenable_i);
			state_nxt.fast_rc_div            = wimg[`OSC_C_FAST_RC_DIV];
			state_nxt.sleep_on_wait          = wimg[`OSC_C_SLEEP_WAIT];
			state_nxt.clock_fail_flag        = wimg[`OSC_C_CLK_FAIL];
			state_nxt.clk.usb_fast_rc_select = wimg[`OSC_C_USB_FAST_RC];
			state_nxt.clk.sec_osc_enable     = wimg[`OSC_C_SEC_ENABLE];
			// a write while the divider is still adjusting is dropped
			if (pb_ready) begin
				state_nxt.pb_div = wimg[`OSC_C_PB_DIV];
			end
			if (!locked) begin
				state_nxt.pll_mult = wimg[`OSC_C_PLL_MULT];
				state_nxt.nxt_src  = wimg[`OSC_C_NXT_SRC];
				// switch request is write-one; a zero does not abort a switch
				state_nxt.switch_req = state_r.switch_req | wimg[`OSC_C_SWITCH_REQ];
			end
			// lock is set-only so software cannot undo it
			state_nxt.sel_lock = state_r.sel_lock | wimg[`OSC_C_SEL_LOCK];
		end
		// a failure in the cycle of a clearing write still sets the flag
		if (pins_s.clock_fail) begin
			state_nxt.clock_fail_flag = 1'b1;
		end

		// tuning register write
		if (wr && avs_address_i == `OSC_REG_TRIM) begin
			wimg = byte_merge(trim_img, avs_writedata_i, avs_byteenable_i);
			state_nxt.trim = wimg[`OSC_T_TRIM];
		end

		// reference register write; divider and source land in the stage first
		if (wr && avs_address_i == `OSC_REG_REF) begin
			wimg = byte_merge(ref_img, avs_writedata_i, avs_byteenable_i);
			state_nxt.ref_div_stage   = wimg[`OSC_R_DIV];
			state_nxt.ref_sel_stage   = wimg[`OSC_R_SEL];
			state_nxt.ref_on          = wimg[`OSC_R_ON];
			state_nxt.ref_stop_idle   = wimg[`OSC_R_STOP_IDLE];
			state_nxt.refc.out_enable = wimg[`OSC_R_OUT_EN];
			state_nxt.ref_run_sleep   = wimg[`OSC_R_RUN_SLEEP];
			state_nxt.ref_div_switch  = state_r.ref_div_switch | wimg[`OSC_R_DIV_SWITCH];
		end

		// reference staging: disabled generator takes values at once
		if (!state_r.ref_on) begin
			state_nxt.refc.divider = state_r.ref_div_stage;
			state_nxt.refc.source  = state_r.ref_sel_stage;
			state_nxt.ref_div_switch = 1'b0;
			state_nxt.ref_cnt        = '0;
		end else if (state_r.ref_div_switch) begin
			// enabled: apply only after the switch has run its course
			if (state_r.ref_cnt == REF_LAST) begin
				state_nxt.refc.divider   = state_r.ref_div_stage;
				state_nxt.refc.source    = state_r.ref_sel_stage;
				state_nxt.ref_div_switch = 1'b0;
				state_nxt.ref_cnt        = '0;
			end else begin
				state_nxt.ref_cnt = state_r.ref_cnt + 8'h01;
			end
		end
		// request is active while the generator runs or switches
		state_nxt.ref_active = state_r.ref_on | state_r.ref_div_switch;
		// run in sleep has no meaning for core and peripheral sources
		state_nxt.refc.enable = state_r.ref_on
			& ~(state_r.ref_stop_idle & state_r.idle_mode)
			& ~(state_r.sleep_mode & ~(state_r.ref_run_sleep
				& state_r.refc.source != `OSC_REF_SEL_CORE
				& state_r.refc.source != `OSC_REF_SEL_PERIPH));

		// clock switch sequencer
		case (state_r.nxt_src)
			`OSC_SRC_FAST_RC_PLL: tgt_rdy = state_r.sys_pll_locked;
			`OSC_SRC_PRIMARY_PLL: tgt_rdy = state_r.sys_pll_locked;
			`OSC_SRC_SECONDARY:   tgt_rdy = state_r.sec_ready;
			default:              tgt_rdy = 1'b1;
		endcase
		case (state_r.sw_state)
			SW_IDLE: begin
				state_nxt.sw_cnt = '0;
				if (state_r.switch_req) begin
					state_nxt.sw_state = SW_WAIT_READY;
				end
			end
			SW_WAIT_READY: begin
				// waits without limit for the new source to come up
				if (tgt_rdy) begin
					state_nxt.sw_state = SW_SETTLE;
				end
			end
			SW_SETTLE: begin
				if (state_r.sw_cnt == SW_LAST) begin
					state_nxt.clk.core_clock_src = state_r.nxt_src;
					state_nxt.switch_req         = 1'b0;
					state_nxt.sw_state           = SW_IDLE;
				end else begin
					state_nxt.sw_cnt = state_r.sw_cnt + 8'h01;
				end
			end
			default: begin
				state_nxt.sw_state = SW_IDLE;
			end
		endcase

		// wait instruction chooses sleep or idle and wins over a wake in the same cycle; a wake event alone ends both
		if (wait_exec_i) begin
			state_nxt.sleep_mode = state_r.sleep_on_wait;
			state_nxt.idle_mode  = ~state_r.sleep_on_wait;
		end else if (wake_event_i) begin
			state_nxt.sleep_mode = 1'b0;
			state_nxt.idle_mode  = 1'b0;
		end

		// straps are taken once, one cycle after reset is released
		if (state_r.strap_pend) begin
			state_nxt.strap_pend         = 1'b0;
			state_nxt.sw_mon_cfg         = straps_s.switch_monitor_config;
			state_nxt.nxt_src            = straps_s.initial_source_config;
			state_nxt.clk.core_clock_src = straps_s.initial_source_config;
		end

		// synchronous reset
		if (srst_i) begin
			state_nxt             = '0;
			state_nxt.strap_pend  = 1'b1;
			state_nxt.waitreq     = 1'b1;
			state_nxt.sw_state    = SW_IDLE;
			state_nxt.fast_rc_div = `OSC_FAST_RC_DIV_RST;
			state_nxt.pb_div      = `OSC_PB_DIV_RST;
			state_nxt.pll_mult    = `OSC_PLL_MULT_RST;
		end

		// decoded settings follow their fields
		state_nxt.clk.fast_rc_ratio = RATIO_TAB[state_nxt.fast_rc_div*9 +: 9];
		state_nxt.clk.pll_factor    = FACTOR_TAB[state_nxt.pll_mult*5 +: 5];
		// pll runs while either the current or the next source needs it
		state_nxt.clk.pll_enable =
			state_nxt.clk.core_clock_src == `OSC_SRC_FAST_RC_PLL
			| state_nxt.clk.core_clock_src == `OSC_SRC_PRIMARY_PLL
			| state_nxt.nxt_src == `OSC_SRC_FAST_RC_PLL
			| state_nxt.nxt_src == `OSC_SRC_PRIMARY_PLL;
	end

	// state register
	always_ff @(posedge clk_sys_i) begin
		state_r <= state_nxt;
	end

	// outputs straight from flip-flops
	assign avs_readdata_o    = state_r.rdata;
	assign avs_waitrequest_o = state_r.waitreq;
	assign clk_cfg_o         = state_r.clk;
	assign ref_cfg_o         = state_r.refc;
	assign fast_rc_trim_o    = state_r.trim;
	assign periph_clk_tick_o = pb_tick;
	assign sleep_mode_o      = state_r.sleep_mode;
	assign idle_mode_o       = state_r.idle_mode;

endmodule // osc_source_ctrl

//--- include/osc_map.svh
`ifndef OSC_MAP_SVH
`define OSC_MAP_SVH

// register word indices on the avalon port (word address)
`define OSC_REG_CTRL          2'h0
`define OSC_REG_TRIM          2'h1
`define OSC_REG_REF           2'h2

// oscillator control register fields
`define OSC_C_FAST_RC_DIV     26:24
`define OSC_C_SEC_READY       22
`define OSC_C_PB_READY        21
`define OSC_C_PB_DIV          20:19
`define OSC_C_PLL_MULT        18:16
`define OSC_C_CUR_SRC         14:12
`define OSC_C_NXT_SRC         10:8
`define OSC_C_SEL_LOCK        7
`define OSC_C_USB_LOCK        6
`define OSC_C_SYS_LOCK        5
`define OSC_C_SLEEP_WAIT      4
`define OSC_C_CLK_FAIL        3
`define OSC_C_USB_FAST_RC     2
`define OSC_C_SEC_ENABLE      1
`define OSC_C_SWITCH_REQ      0

// fast rc tuning register field
`define OSC_T_TRIM            5:0

// reference clock control register fields
`define OSC_R_DIV             30:16
`define OSC_R_ON              15
`define OSC_R_STOP_IDLE       13
`define OSC_R_OUT_EN          12
`define OSC_R_RUN_SLEEP       11
`define OSC_R_DIV_SWITCH      9
`define OSC_R_ACTIVE          8
`define OSC_R_SEL             3:0

// reset values
`define OSC_FAST_RC_DIV_RST   3'h1
`define OSC_PB_DIV_RST        2'h3
`define OSC_PLL_MULT_RST      3'h0

// switch-monitor config bit that makes the lock bit effective
`define OSC_CFG_LOCKABLE      1

// source codes that need a ready oscillator before a switch, then reference source codes
`define OSC_SRC_FAST_RC_PLL   3'h1
`define OSC_SRC_PRIMARY_PLL   3'h3
`define OSC_SRC_SECONDARY     3'h4
`define OSC_REF_SEL_CORE      4'h0
`define OSC_REF_SEL_PERIPH    4'h1

// timing in ns
`define OSC_CLK_PERIOD_NS     100
`define OSC_SWITCH_SETTLE_NS  800
`define OSC_REF_SWITCH_NS     400

// lookup tables, entry 0 in the low bits
`define OSC_FAST_RC_RATIO_TAB {9'h100, 9'h040, 9'h020, 9'h010, 9'h008, 9'h004, 9'h002, 9'h001}
`define OSC_PLL_FACTOR_TAB    {5'h18, 5'h15, 5'h14, 5'h13, 5'h12, 5'h11, 5'h10, 5'h0F}

`endif

//--- include/osc_pkg.sv
package osc_pkg;

	// clock switch sequencer states
	typedef enum logic [1:0] {
		SW_IDLE,
		SW_WAIT_READY,
		SW_SETTLE
	} osc_sw_state_type;

	// oscillator status pins, all asynchronous to clk_sys_i
	typedef struct packed {
		logic sec_osc_stable;
		logic usb_pll_lock;
		logic sys_pll_lock;
		logic clock_fail;
	} osc_pin_type;

	// configuration straps from nonvolatile memory
	typedef struct packed {
		logic [1:0] switch_monitor_config;
		logic [2:0] initial_source_config;
	} osc_strap_type;

	// settings toward the oscillators and pll
	typedef struct packed {
		logic [8:0] fast_rc_ratio;
		logic [4:0] pll_factor;
		logic [2:0] core_clock_src;
		logic       pll_enable;
		logic       sec_osc_enable;
		logic       usb_fast_rc_select;
	} osc_clk_cfg_type;

	// settings toward the reference clock generator
	typedef struct packed {
		logic [14:0] divider;
		logic [3:0]  source;
		logic        enable;
		logic        out_enable;
	} osc_ref_cfg_type;

endpackage

//--- core/osc_sync2.sv
`timescale 1ns/1ps
module osc_sync2 #(
	parameter int W = 1
) (
	// clock
	input  wire logic         clk_sys_i,
	// asynchronous levels in, synchronised levels out
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	// first stage feeds only the second stage
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} osc_sync_state_type;

	osc_sync_state_type state_r;   // both stages
	osc_sync_state_type state_nxt; // next value

	// shift one stage per clock
	always_comb begin
		state_nxt        = state_r;
		state_nxt.meta   = d_i;
		state_nxt.stable = state_r.meta;
	end

	// no reset: levels settle within two clocks anyway
	always_ff @(posedge clk_sys_i) begin
		state_r <= state_nxt;
	end

	assign q_o = state_r.stable;

endmodule // osc_sync2

//--- core/osc_pb_div.sv
`timescale 1ns/1ps
`include "osc_map.svh"
module osc_pb_div
	import osc_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       srst_i,
	// divisor code from the control register
	input  wire logic [1:0] div_code_i,
	// one-cycle tick per peripheral clock, and divisor ready
	output logic            tick_o,
	output logic            ready_o
);

	typedef struct packed {
		logic [1:0] active; // divisor in use
		logic [2:0] cnt;    // cycles into the current period
		logic       tick;
		logic       ready;
	} osc_pb_state_type;

	localparam logic [2:0] ONE = 3'h1;

	osc_pb_state_type state_r;   // registered state
	osc_pb_state_type state_nxt; // next state
	logic [2:0]       limit;     // last count of a period

	// new divisor is taken only at a period boundary, so no short tick appears
	always_comb begin
		state_nxt      = state_r;
		state_nxt.tick = 1'b0;
		limit          = (ONE << state_r.active) - ONE;
		if (state_r.cnt == limit) begin
			state_nxt.cnt    = '0;
			state_nxt.tick   = 1'b1;
			state_nxt.active = div_code_i;
		end else begin
			state_nxt.cnt = state_r.cnt + ONE;
		end
		// ready drops while a new divisor waits for the boundary
		state_nxt.ready = (state_nxt.active == div_code_i);
		if (srst_i) begin
			state_nxt.active = `OSC_PB_DIV_RST;
			state_nxt.cnt    = '0;
			state_nxt.tick   = 1'b0;
			state_nxt.ready  = 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk_sys_i) begin
		state_r <= state_nxt;
	end

	assign tick_o  = state_r.tick;
	assign ready_o = state_r.ready;

endmodule // osc_pb_div

//--- verif/osc_source_ctrl_assertions.sv
`timescale 1ns/1ps
`include "osc_map.svh"
module osc_chk
	import osc_pkg::*;
(
	// clock and reset
	input wire logic            clk_sys_i,
	input wire logic            srst_i,
	// register bus
	input wire logic [1:0]      avs_address_i,
	input wire logic            avs_read_i,
	input wire logic            avs_write_i,
	input wire logic [31:0]     avs_readdata_o,
	input wire logic            avs_waitrequest_o,
	// power events
	input wire logic            wait_exec_i,
	input wire logic            wake_event_i,
	// settings and modes
	input wire osc_clk_cfg_type clk_cfg_o,
	input wire osc_ref_cfg_type ref_cfg_o,
	input wire logic            periph_clk_tick_o,
	input wire logic            sleep_mode_o,
	input wire logic            idle_mode_o
);
	// cycles since the last accepted write; reset parks them at the top so strap loads pass
	logic [3:0] ctl_age_r;
	logic [3:0] ref_age_r;
	logic       ack;
	assign ack = avs_write_i & ~avs_waitrequest_o;

	// saturating age counters
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ctl_age_r <= 4'hF;
			ref_age_r <= 4'hF;
		end else begin
			ctl_age_r <= (ack && avs_address_i == `OSC_REG_CTRL) ? 4'h0 : ctl_age_r + {3'h0, ~&ctl_age_r};
			ref_age_r <= (ack && avs_address_i == `OSC_REG_REF) ? 4'h0 : ref_age_r + {3'h0, ~&ref_age_r};
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	a_ratio_legal: assert property ($onehot(clk_cfg_o.fast_rc_ratio) && !clk_cfg_o.fast_rc_ratio[7])
		else $error("illegal fast rc ratio");
	a_factor_legal: assert property (clk_cfg_o.pll_factor inside {[5'h0F:5'h15], 5'h18})
		else $error("illegal pll factor");
	a_tick_gap_max: assert property (periph_clk_tick_o |=> ##[0:7] periph_clk_tick_o)
		else $error("tick gap above eight");
	a_wait_one_mode: assert property (wait_exec_i && !wake_event_i |=> sleep_mode_o != idle_mode_o)
		else $error("wait mode wrong");
	a_sec_en_write: assert property ($changed(clk_cfg_o.sec_osc_enable) |-> ctl_age_r <= 4'h1)
		else $error("secondary enable moved alone");
	a_switch_settles: assert property ($changed(clk_cfg_o.core_clock_src) |-> ctl_age_r >= 4'h8)
		else $error("source switched too soon");
	a_ref_apply_win: assert property ($changed(ref_cfg_o.divider) |-> ref_age_r <= 4'h6)
		else $error("reference divider moved alone");
	a_ctrl_gaps_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == `OSC_REG_CTRL
		|-> avs_readdata_o[23] == 1'b0 && avs_readdata_o[15] == 1'b0 && avs_readdata_o[11] == 1'b0)
		else $error("unimplemented bit set");

	// main scenarios reached
	c_sleep: cover property (wait_exec_i ##1 sleep_mode_o);
	c_switch: cover property ($changed(clk_cfg_o.core_clock_src));
	c_ref: cover property ($changed(ref_cfg_o.divider));
endmodule // osc_chk

bind osc_source_ctrl osc_chk i_osc_chk (.clk_sys_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i,
	.avs_readdata_o, .avs_waitrequest_o, .wait_exec_i, .wake_event_i, .clk_cfg_o, .ref_cfg_o,
	.periph_clk_tick_o, .sleep_mode_o, .idle_mode_o);

//--- verif/tb_top.sv
`timescale 1ns/1ps
`include "osc_map.svh"
module tb_top
	import osc_pkg::*;
;
	logic            clk_sys_i = 0;
	logic            srst_i = 1;
	logic [1:0]      adr = 0;
	logic            rd = 0;
	logic            wr = 0;
	logic            wev = 0;
	logic            wk = 0;
	logic            wreq, tick, slp, idl;
	logic [31:0]     wdat = 0;
	logic [31:0]     rdat, rd_data, d1;
	logic [31:0]     seed = 32'h75C67ADD;
	logic [5:0]      trim;
	osc_pin_type     pins = '0;
	osc_strap_type   straps = {2'h2, 3'h2}; // lockable, primary at start
	osc_clk_cfg_type ccfg;
	osc_ref_cfg_type rcfg;
	logic [31:0]     q_exp[$];
	logic [31:0]     q_msk[$];
	int              failures = 0;
	int              n_checks = 0;
	int              n;

	osc_source_ctrl i_osc_source_ctrl (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .osc_pins_i(pins), .straps_i(straps),
		.wait_exec_i(wev), .wake_event_i(wk), .clk_cfg_o(ccfg), .ref_cfg_o(rcfg),
		.fast_rc_trim_o(trim), .periph_clk_tick_o(tick), .sleep_mode_o(slp), .idle_mode_o(idl));

	// free running clock
	initial begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results();
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// one transfer held until waitrequest is seen low; a read notes its expectation
	task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d, input logic [31:0] m = 0);
		int t = 0;
		@(posedge clk_sys_i);
		if (!w) begin
			q_exp.push_back(d);
			q_msk.push_back(m);
		end
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk_sys_i);
			t++;
		end while (wreq !== 1'b0 && t < 50);
		if (t >= 50)
			failures++;
		rd_data = rdat;
		wr <= 0;
		rd <= 0;
	endtask

	// read until a bit reaches a level; no timing is assumed
	task automatic poll(input logic [1:0] a, input int b, input logic v);
		int t = 0;
		do begin
			bus(0, a, 0);
			t++;
		end while (rd_data[b] !== v && t < 100);
		check("polled bit", {31'h0, rd_data[b]}, {31'h0, v});
	endtask

	// one cycle wait (w) or wake pulse
	task automatic pulse(input logic w);
		@(posedge clk_sys_i);
		wev <= w;
		wk <= !w;
		@(posedge clk_sys_i);
		wev <= 0;
		wk <= 0;
		@(posedge clk_sys_i);
	endtask

	// read answers are compared against the oldest note
	always @(posedge clk_sys_i) begin
		if (rd && wreq === 1'b0 && q_exp.size() > 0) begin
			check("read word", rdat & q_msk[0], q_exp[0] & q_msk[0]);
			void'(q_exp.pop_front());
			void'(q_msk.pop_front());
		end
	end

	initial begin
		repeat (4) @(posedge clk_sys_i);
		srst_i <= 0;
		bus(0, `OSC_REG_CTRL, 32'h01382200, 32'hFFFFFFFF);
		bus(0, `OSC_REG_REF, 0, 32'hFFFFFFFF);
		bus(1, 2'h3, 32'hFFFFFFFF);
		bus(0, 2'h3, 0, 32'hFFFFFFFF);
		for (int c = 0; c < 8; c++) begin
			bus(1, `OSC_REG_CTRL, {5'h0, c[2:0], 5'h3, c[2:0], 16'h2202});
			repeat (2) @(posedge clk_sys_i);
			check("fast rc ratio", {23'h0, ccfg.fast_rc_ratio}, c == 7 ? 32'h100 : 32'h1 << c);
			check("pll factor", {27'h0, ccfg.pll_factor}, c == 7 ? 32'h18 : 32'hF + c);
		end
		for (int c = 0; c < 4; c++) begin
			poll(`OSC_REG_CTRL, 21, 1);
			bus(1, `OSC_REG_CTRL, {5'h0, 3'h1, 3'h0, c[1:0], 3'h7, 16'h0200});
			poll(`OSC_REG_CTRL, 21, 1);
			bus(0, `OSC_REG_CTRL, {11'h0, c[1:0], 19'h0}, 32'h00180000);
			n = 0;
			do @(posedge clk_sys_i); while (tick !== 1'b1 && ++n < 20);
			n = 0;
			do begin
				@(posedge clk_sys_i);
				n++;
			end while (tick !== 1'b1 && n < 20);
			check("tick gap", n, 32'h1 << c);
		end
		// second write lands while ready is low
		n = 0;
		do @(posedge clk_sys_i); while (tick !== 1'b1 && ++n < 20);
		bus(1, `OSC_REG_CTRL, 32'h01170200);
		bus(1, `OSC_REG_CTRL, 32'h010F0200);
		poll(`OSC_REG_CTRL, 21, 1);
		bus(0, `OSC_REG_CTRL, 32'h00100000, 32'h00180000);
		repeat (3) begin
			seed = lfsr(seed);
			bus(1, `OSC_REG_TRIM, seed);
			bus(0, `OSC_REG_TRIM, {26'h0, seed[5:0]}, 32'hFFFFFFFF);
			check("trim out", {26'h0, trim}, {26'h0, seed[5:0]});
		end
		bus(1, `OSC_REG_CTRL, 32'h011F0001);
		poll(`OSC_REG_CTRL, 0, 0);
		bus(0, `OSC_REG_CTRL, 0, 32'h7000);
		bus(1, `OSC_REG_CTRL, 32'h011F0403);
		repeat (30) @(posedge clk_sys_i);
		bus(0, `OSC_REG_CTRL, 32'h1, 32'h00407001);
		check("sec enable", {31'h0, ccfg.sec_osc_enable}, 32'h1);
		pins.sec_osc_stable <= 1;
		poll(`OSC_REG_CTRL, 0, 0);
		bus(0, `OSC_REG_CTRL, 32'h00404000, 32'h00407000);
		for (int s = 0; s < 2; s++) begin
			bus(1, `OSC_REG_CTRL, 32'h011F0402 | (s << 4));
			pulse(1);
			check("sleep idle", {30'h0, slp, idl}, s ? 32'h2 : 32'h1);
			pulse(0);
			check("woken", {30'h0, slp, idl}, 32'h0);
		end
		pins.clock_fail <= 1;
		pins.usb_pll_lock <= 1;
		pins.sys_pll_lock <= 1;
		repeat (4) @(posedge clk_sys_i);
		pins.clock_fail <= 0;
		repeat (4) @(posedge clk_sys_i);
		bus(0, `OSC_REG_CTRL, 32'h48, 32'h68);
		bus(1, `OSC_REG_CTRL, 32'h011F0406);
		bus(0, `OSC_REG_CTRL, 32'h44, 32'h4C);
		check("usb fast rc", {31'h0, ccfg.usb_fast_rc_select}, 32'h1);
		bus(1, `OSC_REG_CTRL, 32'h011F0306);
		poll(`OSC_REG_CTRL, 5, 1);
		check("pll enable", {31'h0, ccfg.pll_enable}, 32'h1);
		for (int c = 0; c < 9; c++) begin
			seed = lfsr(seed);
			d1 = {1'b0, seed[14:0], 12'h0, c[3:0]};
			bus(1, `OSC_REG_REF, d1);
			repeat (2) @(posedge clk_sys_i);
			check("ref source", {28'h0, rcfg.source}, c);
		end
		bus(1, `OSC_REG_REF, d1 | 32'h8000);
		bus(1, `OSC_REG_REF, d1 ^ 32'h7FFF8000);
		repeat (8) @(posedge clk_sys_i);
		check("ref held", {17'h0, rcfg.divider}, {17'h0, d1[30:16]});
		check("ref enable", {30'h0, rcfg.enable, rcfg.out_enable}, 32'h2);
		bus(1, `OSC_REG_REF, d1 ^ 32'h7FFF8200);
		poll(`OSC_REG_REF, 9, 0);
		check("ref applied", {17'h0, rcfg.divider}, {17'h0, ~d1[30:16]});
		bus(1, `OSC_REG_CTRL, 32'h011F0482);
		bus(1, `OSC_REG_CTRL, 32'h01180402);
		repeat (2) @(posedge clk_sys_i);
		check("locked factor", {27'h0, ccfg.pll_factor}, 32'h18);
		results();
	end

	// watchdog well beyond the expected run
	initial begin
		#2000000;
		failures++;
		results();
	end
endmodule // tb_top
